// ==== rtl/stc_pkg.sv ====
package stc_pkg;

	// Trigger source selection, nine values.
	typedef enum logic [3:0]
	{
		STC_SRC_CONT,
		STC_SRC_TIMER,
		STC_SRC_BUS,
		STC_SRC_EXT,
		STC_SRC_ALARM_ONE_SOURCE,
		STC_SRC_ALARM_TWO_SOURCE,
		STC_SRC_ALARM_THREE_SOURCE,
		STC_SRC_ALARM_FOUR_SOURCE,
		STC_SRC_ABS
	} stc_src_t;

	// Sequencer states.
	typedef enum logic [1:0]
	{
		STC_ST_IDLE,
		STC_ST_WAIT,
		STC_ST_SCAN
	} stc_state_t;

	// Clock rate and time base.
	localparam int unsigned STC_CLK_HZ      = 125000000;
	localparam int unsigned STC_MS_NS       = 1000000;
	localparam int unsigned STC_CLK_NS      = 8;
	// One interval tick is one millisecond, counted in clock cycles.
	localparam int unsigned STC_TICK_CYC    = STC_MS_NS / STC_CLK_NS;
	// Longest interval in milliseconds, 359999.999 s.
	localparam logic [31:0] STC_INTV_MAX_MS = 32'h1575_29ff;
	localparam logic [31:0] STC_INTV_RST    = 32'h0000_0000;
	// Scan count limits; zero means unlimited.
	localparam logic [15:0] STC_CNT_MAX     = 16'hc350;
	localparam logic [15:0] STC_CNT_RST     = 16'h0001;
	// Query tokens, one-hot per answer.
	localparam logic [7:0]  STC_TOK_BUS     = 8'h01;
	localparam logic [7:0]  STC_TOK_IMM     = 8'h02;
	localparam logic [7:0]  STC_TOK_EXT     = 8'h04;
	localparam logic [7:0]  STC_TOK_AL1     = 8'h08;
	localparam logic [7:0]  STC_TOK_AL2     = 8'h10;
	localparam logic [7:0]  STC_TOK_AL3     = 8'h20;
	localparam logic [7:0]  STC_TOK_AL4     = 8'h40;
	localparam logic [7:0]  STC_TOK_ABS     = 8'h80;
	// Absolute time field widths: month, day, hour, minute, second.
	localparam int unsigned STC_ABS_W       = 28;

endpackage : stc_pkg

// ==== rtl/stc_edge_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser with a selectable edge detector behind it.
module stc_edge_sync
	import stc_pkg::*;
(
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic srst,
	// Raw input and edge choice.
	input  wire logic din,
	input  wire logic edge_down,
	// Detected edge pulse.
	output logic      edge_pulse
);

	logic       meta_r;  // First stage, read only by the second.
	logic       sync_r;  // Second stage.
	logic       prev_r;  // Delayed copy for edge detection.
	logic [2:0] fill_r;  // Ones shift in after reset; edges count once full.
	logic       rise_w;  // Rising edge seen.
	logic       fall_w;  // Edge_down edge seen.

	assign rise_w = sync_r & ~prev_r;
	assign fall_w = ~sync_r & prev_r;

	// Shift the input through the chain and register the chosen edge.
	// Edges are ignored until the chain holds real samples, so a line that
	// idles high cannot fake a rising edge right after reset.
	// two-stage synchroniser
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			meta_r     <= 1'b0;
			sync_r     <= 1'b0;
			prev_r     <= 1'b0;
			fill_r     <= 3'h0;
			edge_pulse <= 1'b0;
		end
		else
		begin
			meta_r     <= din;
			sync_r     <= meta_r;
			prev_r     <= sync_r;
			fill_r     <= {fill_r[1:0], 1'b1};
			edge_pulse <= fill_r[2] & (edge_down ? fall_w : rise_w);
		end
	end

endmodule : stc_edge_sync

`default_nettype wire

// ==== rtl/stc_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module stc_top
	import stc_pkg::*;
#(
	parameter int unsigned TICK_CYC = STC_TICK_CYC  // Cycles per millisecond tick.
)
(
	// Clock and reset; srst is the factory reset.
	input  wire logic        clk_sys,
	input  wire logic        srst,
	// Host commands, one-cycle strobes with their data.
	input  wire logic        edge_wr,
	input  wire logic        edge_down_in,
	input  wire logic        src_wr,
	input  wire logic [3:0]  src_in,
	input  wire logic        intv_wr,
	input  wire logic [31:0] intv_ms_in,
	input  wire logic        cnt_wr,
	input  wire logic [15:0] cnt_in,
	input  wire logic        abs_wr,
	input  wire logic [27:0] abs_in,
	input  wire logic [4:0]  abs_wild_in,
	input  wire logic        config_req,
	input  wire logic        init_req,
	input  wire logic        abort_req,
	input  wire logic        bus_trig,
	// Instrument status.
	input  wire logic        measurement_module,
	// Trigger sources from the rest of the instrument.
	input  wire logic        ext_trig_in,
	input  wire logic [3:0]  alarm_evt,
	input  wire logic [27:0] sys_time,
	input  wire logic        scan_done,
	// Settings and state read back.
	output logic             edge_down,
	output logic [7:0]       src_token,
	output logic [31:0]      intv_ms,
	output logic [31:0]      intv_min_ms,
	output logic [31:0]      intv_max_ms,
	output logic [15:0]      scan_count,
	output logic             waiting,
	output logic             cmd_error,
	// Trigger toward the scan sequencer.
	output logic             trig_pulse
);

	stc_src_t    src_r;        // Selected trigger source.
	stc_src_t    src_nxt;      // Next source.
	stc_state_t  state_r;      // Sequencer state.
	stc_state_t  state_nxt;    // Next state.
	logic [15:0] remain_r;     // Scans left; zero count is unlimited.
	logic [27:0] abs_r;        // Target time.
	logic [4:0]  wild_r;       // Wildcard flags per field.
	logic [31:0] tick_cnt_r;   // Cycle counter inside a millisecond.
	logic [31:0] ms_cnt_r;     // Milliseconds since last scan start.
	logic        abs_prev_r;   // Last absolute-match value.
	logic        ext_edge_w;   // Detected external edge.
	logic        abs_match_w;  // Target time reached.
	logic        abs_rise_w;   // Fresh absolute match.
	logic        timer_ok_w;   // Interval elapsed.
	logic        cond_w;       // Trigger condition for the current source.
	logic        fire_w;       // Trigger issued this cycle.
	logic        last_w;       // This trigger uses up the count.
	logic        last_r;       // The trigger just issued used up the count.
	logic [4:0]  field_eq_w;   // Per-field equality or wildcard.
	logic [31:0] intv_clip_w;  // Interval written, clipped to the limit.

	// External edge detection behind the synchroniser.
	stc_edge_sync u_sync
	(
		.clk_sys    (clk_sys),
		.srst       (srst),
		.din        (ext_trig_in),
		.edge_down  (edge_down),
		.edge_pulse (ext_edge_w)
	);

	// Field compare, wildcarded fields always agree.
	// wildcard fields skipped
	assign field_eq_w[4] = wild_r[4] | (sys_time[27:24] == abs_r[27:24]);
	assign field_eq_w[3] = wild_r[3] | (sys_time[23:17] == abs_r[23:17]);
	assign field_eq_w[2] = wild_r[2] | (sys_time[16:12] == abs_r[16:12]);
	assign field_eq_w[1] = wild_r[1] | (sys_time[11:6] == abs_r[11:6]);
	assign field_eq_w[0] = wild_r[0] | (sys_time[5:0] == abs_r[5:0]);
	assign abs_match_w   = &field_eq_w;
	// All wildcards act like continuous; otherwise fire on arrival at the target.
	assign abs_rise_w    = (&wild_r) | (abs_match_w & ~abs_prev_r);

	// Interval counts from the previous start; a short one passes at once.
	// start to start
	assign timer_ok_w = (ms_cnt_r >= intv_ms);

	// Condition for each source.
	always_comb
	begin
		case (src_r)
			STC_SRC_CONT:   cond_w = 1'b1;
			STC_SRC_TIMER:  cond_w = timer_ok_w;
			STC_SRC_BUS:    cond_w = bus_trig;
			STC_SRC_EXT:    cond_w = ext_edge_w;
			STC_SRC_ALARM_ONE_SOURCE: cond_w = alarm_evt[0];
			STC_SRC_ALARM_TWO_SOURCE: cond_w = alarm_evt[1];
			STC_SRC_ALARM_THREE_SOURCE: cond_w = alarm_evt[2];
			STC_SRC_ALARM_FOUR_SOURCE: cond_w = alarm_evt[3];
			STC_SRC_ABS:    cond_w = abs_rise_w;
			default:        cond_w = 1'b0;
		endcase
	end

	assign fire_w = (state_r == STC_ST_WAIT) & cond_w & ~abort_req;
	assign last_w = (remain_r == 16'h0001);

	// Next state of the sequencer.
	always_comb
	begin
		state_nxt = state_r;
		if (abort_req || config_req)
		begin
			state_nxt = STC_ST_IDLE;
		end
		else if (state_r == STC_ST_IDLE)
		begin
			if (init_req)
			begin
				state_nxt = STC_ST_WAIT;
			end
		end
		else if (state_r == STC_ST_WAIT)
		begin
			if (fire_w)
			begin
				state_nxt = STC_ST_SCAN;
			end
		end
		else if (scan_done)
		begin
			state_nxt = last_r ? STC_ST_IDLE : STC_ST_WAIT;
		end
	end

	// Source decode, invalid codes keep the old value.
	always_comb
	begin
		src_nxt = src_r;
		if (config_req)
		begin
			src_nxt = STC_SRC_CONT;
		end
		else if (src_wr && (src_in <= 4'(STC_SRC_ABS)))
		begin
			src_nxt = stc_src_t'(src_in);
		end
	end

	assign intv_clip_w = (intv_ms_in > STC_INTV_MAX_MS) ? STC_INTV_MAX_MS : intv_ms_in;

	// Settings registers; srst is the only reset and is the factory reset.
	// factory reset continuous
	// interval cleared on reset or configure
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			src_r     <= STC_SRC_CONT;
			edge_down <= 1'b0;
			intv_ms   <= STC_INTV_RST;
			abs_r     <= '0;
			wild_r    <= 5'h1f;
			cmd_error <= 1'b0;
		end
		else
		begin
			src_r     <= src_nxt;
			cmd_error <= 1'b0;
			if (edge_wr)
			begin
				if (measurement_module)
				begin
					edge_down <= edge_down_in;
				end
				else
				begin
					cmd_error <= 1'b1;
				end
			end
			if (config_req)
			begin
				intv_ms <= STC_INTV_RST;
			end
			else if (intv_wr)
			begin
				intv_ms <= intv_clip_w;
			end
			if (abs_wr)
			begin
				abs_r  <= abs_in;
				wild_r <= abs_wild_in;
			end
		end
	end

	// Scan state, count and trigger pulse.
	// single pulse, count decremented
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state_r    <= STC_ST_IDLE;
			remain_r   <= STC_CNT_RST;
			scan_count <= STC_CNT_RST;
			trig_pulse <= 1'b0;
			waiting    <= 1'b0;
			abs_prev_r <= 1'b0;
			last_r     <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			trig_pulse <= fire_w;
			waiting    <= (state_nxt == STC_ST_WAIT);
			abs_prev_r <= abs_match_w;
			// The count is already decremented at the trigger, so remember here
			// whether it was the last one; a zero count would read as unlimited.
			if (fire_w)
			begin
				last_r <= last_w;
			end
			if (config_req)
			begin
				scan_count <= STC_CNT_RST;
				remain_r   <= STC_CNT_RST;
			end
			else if (cnt_wr && (cnt_in <= STC_CNT_MAX))
			begin
				scan_count <= cnt_in;
				remain_r   <= cnt_in;
			end
			else if (init_req && (state_r == STC_ST_IDLE))
			begin
				remain_r <= scan_count;
			end
			else if (fire_w && (remain_r != 16'h0000))
			begin
				remain_r <= remain_r - 16'h0001;
			end
		end
	end

	// Millisecond time base, restarted at each scan start.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			tick_cnt_r <= '0;
			ms_cnt_r   <= '0;
		end
		else if (fire_w)
		begin
			tick_cnt_r <= '0;
			ms_cnt_r   <= '0;
		end
		else if (tick_cnt_r == 32'(TICK_CYC - 1))
		begin
			tick_cnt_r <= '0;
			if (ms_cnt_r != 32'hffff_ffff)
			begin
				ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
			end
		end
		else
		begin
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
		end
	end

	// Query answers held in registers.
	// source token
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			src_token   <= STC_TOK_IMM;
			intv_min_ms <= STC_INTV_RST;
			intv_max_ms <= STC_INTV_MAX_MS;
		end
		else
		begin
			intv_min_ms <= STC_INTV_RST;
			intv_max_ms <= STC_INTV_MAX_MS;
			case (src_r)
				STC_SRC_BUS:    src_token <= STC_TOK_BUS;
				STC_SRC_EXT:    src_token <= STC_TOK_EXT;
				STC_SRC_ALARM_ONE_SOURCE: src_token <= STC_TOK_AL1;
				STC_SRC_ALARM_TWO_SOURCE: src_token <= STC_TOK_AL2;
				STC_SRC_ALARM_THREE_SOURCE: src_token <= STC_TOK_AL3;
				STC_SRC_ALARM_FOUR_SOURCE: src_token <= STC_TOK_AL4;
				STC_SRC_ABS:    src_token <= STC_TOK_ABS;
				default:        src_token <= STC_TOK_IMM;
			endcase
		end
	end

endmodule : stc_top

`default_nettype wire

// ==== test/stc_ttl_src.sv ====
`timescale 1ns/1ps
`default_nettype none

// External pulse source; rests at the inactive level between pulses.
module stc_ttl_src #(
	parameter int PW = 250  // Pulse width in cycles, 2 us at 8 ns.
)
(
	// Clock and request.
	input  wire logic clk_sys,
	input  wire logic fire,
	input  wire logic down,
	// Pulse line.
	output logic      ext_trig_in
);
	int n = 0;  // Cycles of pulse left.

	always @(posedge clk_sys)
	begin
		if (fire)
			n <= PW;
		else if (n > 0)
			n <= n - 1;
	end

	// A edge_down edge choice flips the idle level high.
	assign ext_trig_in = (n > 0) ^ down;
endmodule : stc_ttl_src

`default_nettype wire

// ==== test/stc_top_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

// Watches the trigger controller ports.
module stc_top_checker
	import stc_pkg::*;
(
	// Clock and reset.
	input wire logic        clk_sys,
	input wire logic        srst,
	// Host commands.
	input wire logic        edge_wr,
	input wire logic        edge_down_in,
	input wire logic        intv_wr,
	input wire logic [31:0] intv_ms_in,
	input wire logic        cnt_wr,
	input wire logic [15:0] cnt_in,
	input wire logic        config_req,
	input wire logic        init_req,
	input wire logic        abort_req,
	input wire logic        measurement_module,
	// Watched outputs.
	input wire logic        edge_down,
	input wire logic [7:0]  src_token,
	input wire logic [31:0] intv_ms,
	input wire logic [31:0] intv_min_ms,
	input wire logic [31:0] intv_max_ms,
	input wire logic [15:0] scan_count,
	input wire logic        waiting,
	input wire logic        cmd_error,
	input wire logic        trig_pulse
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	trig_once_a: assert property (trig_pulse |=> !trig_pulse)
		else $error("trigger longer than one cycle");
	trig_wait_a: assert property (trig_pulse |-> $past(waiting) && !waiting)
		else $error("trigger outside waiting state");
	abort_block_a: assert property (abort_req |=> !trig_pulse)
		else $error("trigger after abort");
	edge_refuse_a: assert property (edge_wr && !measurement_module |=>
		cmd_error && $stable(edge_down)) else $error("edge write not refused");
	edge_set_a: assert property (edge_wr && measurement_module |=>
		edge_down == $past(edge_down_in) && !cmd_error) else $error("edge write lost");
	cfg_force_a: assert property (config_req |=> intv_ms == 0 && scan_count == 1
		##1 src_token == STC_TOK_IMM) else $error("configure did not restore");
	intv_clip_a: assert property (intv_wr && !config_req |=> intv_ms ==
		($past(intv_ms_in) > STC_INTV_MAX_MS ? STC_INTV_MAX_MS : $past(intv_ms_in)))
		else $error("interval write wrong");
	cnt_set_a: assert property (cnt_wr && cnt_in <= STC_CNT_MAX && !config_req |=>
		scan_count == $past(cnt_in)) else $error("count write wrong");
	lim_val_a: assert property (intv_min_ms == 0 && intv_max_ms == STC_INTV_MAX_MS)
		else $error("interval limits wrong");
	rst_val_a: assert property ($fell(srst) |-> !edge_down && src_token == STC_TOK_IMM
		&& intv_ms == 0) else $error("reset values wrong");

	// Main scenarios reached.
	cover property (init_req ##2 trig_pulse);
	cover property (cmd_error);
	cover property (abort_req && waiting);
endmodule : stc_top_checker

bind stc_top stc_top_checker u_stc_top_checker (.clk_sys(clk_sys), .srst(srst),
	.edge_wr(edge_wr), .edge_down_in(edge_down_in), .intv_wr(intv_wr),
	.intv_ms_in(intv_ms_in), .cnt_wr(cnt_wr), .cnt_in(cnt_in), .config_req(config_req),
	.init_req(init_req), .abort_req(abort_req), .measurement_module(measurement_module),
	.edge_down(edge_down), .src_token(src_token), .intv_ms(intv_ms),
	.intv_min_ms(intv_min_ms), .intv_max_ms(intv_max_ms), .scan_count(scan_count),
	.waiting(waiting), .cmd_error(cmd_error), .trig_pulse(trig_pulse));

`default_nettype wire

// ==== test/scan_trigger_controller_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the scan trigger controller.
module scan_trigger_controller_bench;
	import stc_pkg::*;
	logic        clk_sys = 0;  // System clock.
	logic        srst    = 1;  // Factory reset.
	logic [8:0]  stb     = 0;  // Command strobes by index.
	logic [31:0] dat     = 0;  // Command data.
	logic [4:0]  wild    = 0;  // Time wildcards.
	logic        mm      = 1;  // Measurement module present.
	logic [3:0]  alarm   = 0;  // Alarm events.
	logic [27:0] now     = 0;  // System time.
	logic [2:0]  sd      = 0;  // Scan-done delay line.
	logic        fire    = 0;  // Partner pulse request.
	logic        down    = 0;  // Partner polarity.
	wire         ext;          // External trigger line.
	logic        edge_down, waiting, cmd_error, trig_pulse;
	logic [7:0]  src_token;
	logic [31:0] intv_ms, intv_min_ms, intv_max_ms;
	logic [15:0] scan_count;
	int          failures = 0, num_checks = 0, ntrig = 0, cyc = 0, last = 0, gap = 0;

	stc_top #(.TICK_CYC(4)) u_stc_top (.clk_sys(clk_sys), .srst(srst), .edge_wr(stb[0]),
		.edge_down_in(dat[0]), .src_wr(stb[1]), .src_in(dat[3:0]), .intv_wr(stb[2]),
		.intv_ms_in(dat), .cnt_wr(stb[3]), .cnt_in(dat[15:0]), .abs_wr(stb[4]),
		.abs_in(dat[27:0]), .abs_wild_in(wild), .config_req(stb[5]), .init_req(stb[6]),
		.abort_req(stb[7]), .bus_trig(stb[8]), .measurement_module(mm),
		.ext_trig_in(ext), .alarm_evt(alarm), .sys_time(now), .scan_done(sd[2]),
		.edge_down(edge_down), .src_token(src_token), .intv_ms(intv_ms),
		.intv_min_ms(intv_min_ms), .intv_max_ms(intv_max_ms), .scan_count(scan_count),
		.waiting(waiting), .cmd_error(cmd_error), .trig_pulse(trig_pulse));
	stc_ttl_src u_stc_ttl_src (.clk_sys(clk_sys), .fire(fire), .down(down), .ext_trig_in(ext));

	always #4 clk_sys = ~clk_sys;

	// Counts triggers, times their spacing, ends scans, cuts hangs.
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		sd <= {sd[1:0], trig_pulse === 1'b1};
		if (trig_pulse === 1'b1)
		begin
			ntrig <= ntrig + 1;
			gap <= cyc - last;
			last <= cyc;
		end
		if (cyc == 40000)
		begin
			failures++;
			finish_test();
		end
	end

	// Expected token for each source code; 9 is ignored.
	function automatic logic [7:0] tok(input int i);
		case (i)
			0, 1: return STC_TOK_IMM;
			2: return STC_TOK_BUS;
			3: return STC_TOK_EXT;
			8, 9: return STC_TOK_ABS;
			default: return STC_TOK_AL1 << (i - 4);
		endcase
	endfunction : tok

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wt

	// One-cycle strobe k with its data.
	task automatic cmd(input int k, input logic [31:0] d);
		@(posedge clk_sys);
		stb <= 9'h001 << k;
		dat <= d;
		@(posedge clk_sys);
		stb <= 9'h000;
	endtask : cmd

	// Counts triggers over a window.
	task automatic tw(input string n, input int c, input int e);
		int t0;
		t0 = ntrig;
		wt(c);
		chk(n, ntrig - t0, e);
	endtask : tw

	task automatic pulse(input logic [3:0] v);
		@(posedge clk_sys) alarm <= v;
		@(posedge clk_sys) alarm <= 0;
	endtask : pulse

	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	initial
	begin
		logic [31:0] r;
		void'($urandom(32'h93f2));
		repeat (10) @(posedge clk_sys);
		srst <= 0;
		wt(0);
		chk("edge_down", edge_down, 0);
		chk("src_token", src_token, STC_TOK_IMM);
		chk("intv_ms", intv_ms, 0);
		chk("scan_count", scan_count, 1);
		chk("intv_max", intv_max_ms, STC_INTV_MAX_MS);
		for (int i = 0; i < 10; i++)
		begin
			cmd(1, i);
			wt(1);
			chk("src_token", src_token, tok(i));
		end
		@(posedge clk_sys) mm <= 0;
		cmd(0, 1);
		wt(0);
		chk("cmd_error", cmd_error, 1);
		chk("edge_down", edge_down, 0);
		@(posedge clk_sys) mm <= 1;
		for (int i = 0; i < 3; i++)
		begin
			r = i == 0 ? $urandom : STC_INTV_MAX_MS + i - 1;
			cmd(2, r);
			wt(0);
			chk("intv_ms", intv_ms, r > STC_INTV_MAX_MS ? STC_INTV_MAX_MS : r);
		end
		cmd(3, 3);
		cmd(3, 50001);
		wt(0);
		chk("scan_count", scan_count, 3);
		cmd(1, 0);
		cmd(6, 0);
		tw("cont trig", 60, 3);
		chk("waiting", waiting, 0);
		for (int i = 0; i < 2; i++)
		begin
			cmd(1, 1);
			cmd(2, 3 * i);
			cmd(6, 0);
			tw("timer trig", 80, 3);
			chk("gap", gap >= 12 * i && gap <= 12 * i + 8, 1);
			chk("cmd_error", cmd_error, 0);
		end
		cmd(3, 1);
		cmd(1, 2);
		cmd(8, 0);
		tw("idle bus", 5, 0);
		cmd(6, 0);
		tw("bus wait", 5, 0);
		cmd(8, 0);
		tw("bus trig", 5, 1);
		cmd(1, 5);
		cmd(6, 0);
		r = $urandom % 3;
		pulse(4'b0001 << (r + (r > 0)));
		tw("other alarm", 5, 0);
		pulse(4'b0010);
		tw("alarm two", 5, 1);
		r = $urandom;
		@(posedge clk_sys) now <= ~r[27:0];
		cmd(1, 8);
		cmd(4, r);
		cmd(6, 0);
		tw("abs early", 5, 0);
		@(posedge clk_sys) now <= r[27:0];
		tw("abs match", 5, 1);
		@(posedge clk_sys) now <= ~r[27:0];
		wild <= 5'h1f;
		cmd(4, r);
		cmd(6, 0);
		tw("abs wild", 5, 1);
		cmd(1, 3);
		for (int i = 0; i < 2; i++)
		begin
			cmd(0, i);
			@(posedge clk_sys) down <= i;
			cmd(6, 0);
			@(posedge clk_sys) fire <= 1;
			@(posedge clk_sys) fire <= 0;
			tw("ext edge", 300, 1);
			wt(12600);
		end
		@(posedge clk_sys) srst <= 1;
		@(posedge clk_sys) srst <= 0;
		wt(0);
		chk("edge_down", edge_down, 0);
		cmd(3, 0);
		cmd(6, 0);
		wt(20);
		cmd(7, 0);
		wt(0);
		tw("abort", 20, 0);
		cmd(1, 2);
		cmd(6, 0);
		cmd(7, 0);
		cmd(8, 0);
		tw("abort wait", 5, 0);
		cmd(1, 3);
		cmd(2, 5);
		cmd(5, 0);
		wt(1);
		chk("src_token", src_token, STC_TOK_IMM);
		chk("intv_ms", intv_ms, 0);
		chk("scan_count", scan_count, 1);
		finish_test();
	end
endmodule : scan_trigger_controller_bench

`default_nettype wire
